// *** eis_io_sync.sv ***
// External control terminals and sampling sync of the logger, with
// an Avalon-MM register slave. Assumes pins arrive asynchronous to sysClk.
//
// How it works
// - Sync setting: off by default, primary, secondary
// - Primary drives sync square wave on output
// - Secondary follows sync input and relays it
// - Secondary rejects local start and stop
// - Secondary blocks timed, pin, pre-trigger, stop-trigger
// - Sync start refused while wireless module registered
// - Sync signal error ends synchronous operation
// - Sync phases at least 100 microseconds each
// - Three input terminals, one output terminal
// - Each input gets one selectable function
// - Toggle alternates; only input three triggers
// - Selectable active edge per input
// - Output off or low on trigger
// - Trigger output low at least 10 ms
// - Start trigger: low until measurement stops
// - Stop trigger: low 10 ms, then released
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module eis_io_sync
#(
  parameter int SYNC_PHASE_CYC = eis_pkg::SYNC_PHASE_CYC,
  parameter int SYNC_TIMEOUT_CYC = eis_pkg::SYNC_TIMEOUT_CYC,
  parameter int TRIG_PULSE_CYC = eis_pkg::TRIG_PULSE_CYC
)
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Sync pins
  input wire logic syncIn,
  output logic syncOut,
  // Control input pins
  input wire logic [2:0] ctrlIn,
  // Open-drain trigger output pin
  output logic trigOut,
  output logic trigOutOe,
  // Instrument interface
  input wire logic wirelessRegistered,
  input wire logic timedStart,
  input wire logic timedStop,
  output logic measuring,
  output logic sampleTick,
  output logic eventMark,
  output logic preTrigActive
);

  initial
  begin
    if (TRIG_PULSE_CYC < 1 || SYNC_PHASE_CYC < 8)
      $error("eis_io_sync: bad timing parameters");
  end

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] inLevel;
  logic [2:0] inRise;
  logic [2:0] inFall;
  logic syncLevel;
  logic syncRise;
  logic syncFall;

  for (genvar i = 0; i < eis_pkg::NUM_INPUTS; i++)
  begin : g_in
    eis_edge_sync u_in
    (
      .sysClk(sysClk),
      .arst_n(arst_n),
      .pinIn(ctrlIn[i]),
      .level(inLevel[i]),
      .rise(inRise[i]),
      .fall(inFall[i])
    );
  end

  eis_edge_sync u_syncIn
  (
    .sysClk(sysClk),
    .arst_n(arst_n),
    .pinIn(syncIn),
    .level(syncLevel),
    .rise(syncRise),
    .fall(syncFall)
  );

  //////////////////////////////////////////////////////////////////////
  // Registers

  eis_pkg::eis_ctrl_t ctrl;
  eis_pkg::eis_incfg_t [2:0] incfg;
  logic syncErr;
  logic refused;
  logic ack;
  logic [31:0] rdata;
  eis_pkg::eis_ctrl_t next_ctrl;
  eis_pkg::eis_incfg_t [2:0] next_incfg;
  logic next_syncErr;
  logic next_refused;
  logic next_ack;
  logic [31:0] next_rdata;

  logic linkErr;
  logic linkTick;
  logic refuseEv;
  logic isSecondary;
  logic busReq;
  logic [2:0] cmdPulse;
  logic [31:0] statusWord;
  logic trigActive;
  logic armed;

  assign busReq = avsRead | avsWrite;
  assign avsWaitrequest = busReq & ~ack;
  assign avsReaddata = rdata;
  assign isSecondary = ctrl.syncMode == eis_pkg::SYNC_SECONDARY;
  assign cmdPulse = (avsWrite && ack && avsAddress == eis_pkg::OFS_CMD) ?
                    avsWritedata[2:0] : 3'h0;

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[eis_pkg::ST_MEAS] = measuring;
    statusWord[eis_pkg::ST_ARMED] = armed;
    statusWord[eis_pkg::ST_SYNC_ERR] = syncErr;
    statusWord[eis_pkg::ST_TRIG_OUT] = trigActive;
    statusWord[eis_pkg::ST_REFUSED] = refused;
    statusWord[eis_pkg::ST_LEVEL0 +: 3] = inLevel;
  end

  always_comb
  begin
    next_ctrl = ctrl;
    next_incfg = incfg;
    next_ack = busReq & ~ack;
    next_rdata = rdata;
    next_syncErr = syncErr;
    next_refused = refused;
    if (busReq && !ack && avsRead)
    begin
      case (avsAddress)
        eis_pkg::OFS_CTRL: next_rdata = {25'h0000000, ctrl};
        eis_pkg::OFS_INCFG: next_rdata = {20'h00000, incfg};
        eis_pkg::OFS_STATUS: next_rdata = statusWord;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (avsWrite && ack)
    begin
      case (avsAddress)
        eis_pkg::OFS_CTRL: next_ctrl = avsWritedata[6:0];
        eis_pkg::OFS_INCFG: next_incfg = avsWritedata[11:0];
        eis_pkg::OFS_STATUS:
        begin
          if (avsWritedata[eis_pkg::ST_SYNC_ERR])
            next_syncErr = 1'b0;
          if (avsWritedata[eis_pkg::ST_REFUSED])
            next_refused = 1'b0;
        end
        default: next_rdata = rdata;
      endcase
    end
    // Error drops the sync setting back to off; hardware wins
    if (linkErr)
    begin
      next_ctrl.syncMode = eis_pkg::SYNC_OFF;
      next_syncErr = 1'b1;
    end
    if (refuseEv)
      next_refused = 1'b1;
  end

  always_ff @(posedge sysClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= eis_pkg::CTRL_RESET;
      incfg <= {3{eis_pkg::INCFG_RESET}};
      syncErr <= 1'b0;
      refused <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      incfg <= next_incfg;
      syncErr <= next_syncErr;
      refused <= next_refused;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sync link

  eis_sync_link
  #(
    .PHASE_CYC(SYNC_PHASE_CYC),
    .TIMEOUT_CYC(SYNC_TIMEOUT_CYC)
  )
  u_link
  (
    .sysClk(sysClk),
    .arst_n(arst_n),
    .syncMode(ctrl.syncMode),
    .inLevel(syncLevel),
    .inRise(syncRise),
    .inFall(syncFall),
    .syncOut(syncOut),
    .tick(linkTick),
    .linkErr(linkErr)
  );

  //////////////////////////////////////////////////////////////////////
  // Control input decode

  logic [2:0] inEdge;
  logic pinStart;
  logic pinStop;
  logic pinToggle;
  logic pinTrig;
  logic pinEvent;

  always_comb
  begin
    pinStart = 1'b0;
    pinStop = 1'b0;
    pinToggle = 1'b0;
    pinTrig = 1'b0;
    pinEvent = 1'b0;
    for (int i = 0; i < eis_pkg::NUM_INPUTS; i++)
    begin
      inEdge[i] = incfg[i].risingEdge ? inRise[i] : inFall[i];
      case (incfg[i].func)
        // Start, stop and toggle do not exist on the third input
        eis_pkg::FN_START: pinStart |= inEdge[i] & (i != 2);
        eis_pkg::FN_STOP: pinStop |= inEdge[i] & (i != 2);
        eis_pkg::FN_TOGGLE: pinToggle |= inEdge[i] & (i != 2);
        eis_pkg::FN_TRIGGER: pinTrig |= inEdge[i] & (i == 2);
        eis_pkg::FN_EVENT: pinEvent |= inEdge[i];
        default: pinEvent |= 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Measurement control

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } eis_meas_t;

  eis_meas_t meas;
  eis_meas_t next_meas;
  logic holdRun;
  logic [31:0] pulseCnt;
  logic evMark;
  logic next_holdRun;
  logic [31:0] next_pulseCnt;
  logic next_evMark;

  logic localStart;
  logic localStop;
  logic wantStart;
  logic wantStop;
  logic startBlocked;
  logic trigEv;
  logic startFire;
  logic stopFire;
  logic stopTrigOk;

  always_comb
  begin
    // Pins, timer and keys all count as local requests
    localStart = cmdPulse[eis_pkg::CMD_START] | pinStart |
                 (pinToggle & meas == ST_IDLE) |
                 (timedStart & ctrl.timedEn);
    localStop = cmdPulse[eis_pkg::CMD_STOP] | pinStop |
                (pinToggle & meas != ST_IDLE) |
                (timedStop & ctrl.timedEn);
    // Secondary ignores every local start or stop
    wantStart = isSecondary ? linkTick : localStart;
    wantStop = isSecondary ? 1'b0 : localStop;
    startBlocked = ctrl.syncMode != eis_pkg::SYNC_OFF & wirelessRegistered;
    refuseEv = (meas == ST_IDLE) & ((wantStart & startBlocked) |
               (isSecondary & (localStart | localStop)));
    trigEv = cmdPulse[eis_pkg::CMD_TRIG] | pinTrig;
    stopTrigOk = ctrl.stopTrigEn & ~isSecondary;
    startFire = 1'b0;
    stopFire = 1'b0;
    next_meas = meas;
    case (meas)
      ST_IDLE:
      begin
        if (wantStart && !startBlocked)
          next_meas = ctrl.startTrigEn ? ST_WAIT : ST_RUN;
      end
      ST_WAIT:
      begin
        if (wantStop)
          next_meas = ST_IDLE;
        else if (trigEv)
        begin
          next_meas = ST_RUN;
          startFire = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (wantStop)
          next_meas = ST_IDLE;
        else if (trigEv && stopTrigOk)
        begin
          next_meas = ST_IDLE;
          stopFire = 1'b1;
        end
      end
      default:
      begin
        next_meas = ST_IDLE;
      end
    endcase
    // A broken sync signal stops the measurement it paced
    if (linkErr)
      next_meas = ST_IDLE;
  end

  //////////////////////////////////////////////////////////////////////
  // Trigger output and event mark

  always_comb
  begin
    next_evMark = pinEvent;
    next_holdRun = holdRun;
    next_pulseCnt = (pulseCnt != 32'h0000_0000) ? pulseCnt - 32'h0000_0001 : pulseCnt;
    // Held low from the start trigger until the run ends
    if (startFire)
      next_holdRun = 1'b1;
    else if (next_meas != ST_RUN)
      next_holdRun = 1'b0;
    // Every activation guarantees the minimum low time
    if (startFire || stopFire)
      next_pulseCnt = 32'(TRIG_PULSE_CYC);
  end

  always_ff @(posedge sysClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meas <= ST_IDLE;
      holdRun <= 1'b0;
      pulseCnt <= 32'h0000_0000;
      evMark <= 1'b0;
    end
    else
    begin
      meas <= next_meas;
      holdRun <= next_holdRun;
      pulseCnt <= next_pulseCnt;
      evMark <= next_evMark;
    end
  end

  // Registered pin drive; trigger output setting gates it
  logic oeReg;

  assign trigActive = holdRun | (pulseCnt != 32'h0000_0000);

  always_ff @(posedge sysClk or negedge arst_n)
  begin
    if (!arst_n)
      oeReg <= 1'b0;
    else
      oeReg <= ctrl.trigOutEn & trigActive;
  end

  assign trigOut = 1'b0;
  assign trigOutOe = oeReg;
  assign armed = meas == ST_WAIT;
  assign measuring = meas == ST_RUN;
  assign eventMark = evMark;
  // Secondaries never capture pre-trigger data
  assign preTrigActive = armed & ctrl.preTrigEn & ~isSecondary;
  assign sampleTick = linkTick;

endmodule

// *** eis_pkg.sv ***
// Constants, register map and carrier types of the external I/O and sync block.
// Assumes a 100 MHz system clock; all pin timing is derived from that rate.
package eis_pkg;

  localparam int CLK_MHZ = 100;

  // Sync pin phases: shortest high or low, in microseconds
  localparam int SYNC_PHASE_US = 100;
  localparam int SYNC_PHASE_CYC = SYNC_PHASE_US * CLK_MHZ;
  // Slack for the two-flop sampling jitter on an incoming phase
  localparam int SYNC_TOL_CYC = 4;
  // Phase longer than this means the chain is broken
  localparam int SYNC_TIMEOUT_CYC = 8 * SYNC_PHASE_CYC;

  // Trigger output low pulse, in milliseconds
  localparam int TRIG_PULSE_MS = 10;
  localparam int TRIG_PULSE_CYC = TRIG_PULSE_MS * 1000 * CLK_MHZ;

  localparam int NUM_INPUTS = 3;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_INCFG = 5'h04;
  localparam logic [4:0] OFS_CMD = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;

  // Sync settings
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_PRIMARY = 2'h1;
  localparam logic [1:0] SYNC_SECONDARY = 2'h2;

  // Control input functions
  localparam logic [2:0] FN_OFF = 3'h0;
  localparam logic [2:0] FN_START = 3'h1;
  localparam logic [2:0] FN_STOP = 3'h2;
  localparam logic [2:0] FN_TOGGLE = 3'h3;
  localparam logic [2:0] FN_TRIGGER = 3'h4;
  localparam logic [2:0] FN_EVENT = 3'h5;

  // Command bits (write only, self clearing)
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_TRIG = 2;

  // Status bits
  localparam int ST_MEAS = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_SYNC_ERR = 2;
  localparam int ST_TRIG_OUT = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_LEVEL0 = 8;

  typedef struct packed {
    logic timedEn;
    logic preTrigEn;
    logic stopTrigEn;
    logic startTrigEn;
    logic trigOutEn;
    logic [1:0] syncMode;
  } eis_ctrl_t;

  localparam eis_ctrl_t CTRL_RESET = 7'h00;

  typedef struct packed {
    logic risingEdge;
    logic [2:0] func;
  } eis_incfg_t;

  localparam logic [3:0] INCFG_RESET = 4'h0;

endpackage

// *** eis_edge_sync.sv ***
// Two-flop synchroniser with edge detection for one asynchronous pin.
// Assumes the pin level holds for several clock periods.
`timescale 1ns/1ps
module eis_edge_sync
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic arst_n,
  // Pin and results
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic last;

  always_ff @(posedge sysClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= pinIn;
      stable <= meta;
      last <= stable;
    end
  end

  assign level = stable;
  assign rise = stable & ~last;
  assign fall = ~stable & last;

endmodule

// *** eis_sync_link.sv ***
// Sampling sync link: generates the sync square wave as primary,
// follows and relays it as secondary, and flags a broken signal.
// Assumes edges of the incoming pin already synchronised to sysClk.
`timescale 1ns/1ps
module eis_sync_link
#(
  parameter int PHASE_CYC = eis_pkg::SYNC_PHASE_CYC,
  parameter int TIMEOUT_CYC = eis_pkg::SYNC_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic arst_n,
  // Setting
  input wire logic [1:0] syncMode,
  // Incoming sync, synchronised
  input wire logic inLevel,
  input wire logic inRise,
  input wire logic inFall,
  // Results
  output logic syncOut,
  output logic tick,
  output logic linkErr
);

  initial
  begin
    if (PHASE_CYC <= eis_pkg::SYNC_TOL_CYC || TIMEOUT_CYC <= PHASE_CYC)
      $error("eis_sync_link: bad phase or timeout");
  end

  logic [31:0] cnt;
  logic locked;
  logic [31:0] next_cnt;
  logic next_syncOut;
  logic next_tick;
  logic next_linkErr;
  logic next_locked;

  always_comb
  begin
    next_cnt = cnt;
    next_syncOut = 1'b0;
    next_tick = 1'b0;
    next_linkErr = 1'b0;
    next_locked = 1'b0;
    case (syncMode)
      eis_pkg::SYNC_PRIMARY:
      begin
        // Phase of exactly PHASE_CYC, never shorter
        next_syncOut = syncOut;
        next_cnt = cnt + 32'h0000_0001;
        if (cnt >= 32'(PHASE_CYC - 1))
        begin
          next_cnt = 32'h0000_0000;
          next_syncOut = ~syncOut;
          next_tick = ~syncOut;
        end
      end
      eis_pkg::SYNC_SECONDARY:
      begin
        // Relay for chaining; phases pass through unshortened
        next_syncOut = inLevel;
        next_tick = inRise;
        next_locked = locked;
        next_cnt = cnt + 32'h0000_0001;
        if (inRise || inFall)
        begin
          next_cnt = 32'h0000_0000;
          next_locked = 1'b1;
          // Phase of SYNC_TOL_CYC or more cycles below the minimum is a sync error
          if (locked && cnt < 32'(PHASE_CYC - eis_pkg::SYNC_TOL_CYC))
            next_linkErr = 1'b1;
        end
        else if (locked && cnt >= 32'(TIMEOUT_CYC))
        begin
          next_linkErr = 1'b1;
        end
      end
      default:
      begin
        // Disabled: no signal made or followed
        next_cnt = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge sysClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 32'h0000_0000;
      syncOut <= 1'b0;
      tick <= 1'b0;
      linkErr <= 1'b0;
      locked <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      syncOut <= next_syncOut;
      tick <= next_tick;
      linkErr <= next_linkErr;
      locked <= next_locked;
    end
  end

endmodule

// *** eis_io_sync_checker.sv ***
// Concurrent checks on the pins of eis_io_sync, attached by bind.
// Assumes one clock domain, sysClk, with asynchronous active-low reset.
`timescale 1ns/1ps
module eis_io_sync_checker
#(
  parameter int SYNC_PHASE_CYC = eis_pkg::SYNC_PHASE_CYC,
  parameter int TRIG_PULSE_CYC = eis_pkg::TRIG_PULSE_CYC
)
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic arst_n,
  // Bus
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  // Pins and status
  input wire logic syncOut,
  input wire logic trigOut,
  input wire logic trigOutOe,
  input wire logic measuring,
  input wire logic sampleTick,
  input wire logic eventMark,
  input wire logic preTrigActive
);
  int phCnt;
  int toCnt;
  int next_phCnt;
  int next_toCnt;
  logic prevSync;
  ////////////////////////////////////////////////////////////////////////////////
  // Saturating counters: cycles since last sync change, cycles trigger held
  always_comb
  begin
    next_phCnt = (syncOut != prevSync) ? 1 : ((phCnt < 1000) ? phCnt + 1 : phCnt);
    next_toCnt = !trigOutOe ? 0 : ((toCnt < 1000) ? toCnt + 1 : toCnt);
  end
  // Starts saturated so the first phase after reset is not judged short
  always_ff @(posedge sysClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phCnt <= 1000;
      toCnt <= 0;
      prevSync <= 1'b0;
    end
    else
    begin
      phCnt <= next_phCnt;
      toCnt <= next_toCnt;
      prevSync <= syncOut;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!arst_n);
  property p_trigOd; !trigOut; endproperty
  a_trigOd: assert property (p_trigOd) else $error("trigger pin data not low");
  property p_trigPulse; $fell(trigOutOe) |-> toCnt >= TRIG_PULSE_CYC; endproperty
  a_trigPulse: assert property (p_trigPulse) else $error("trigger pulse short");
  property p_syncPhase; $changed(syncOut) |-> phCnt >= SYNC_PHASE_CYC; endproperty
  a_syncPhase: assert property (p_syncPhase) else $error("sync phase short");
  property p_tickOne; sampleTick |=> !sampleTick; endproperty
  a_tickOne: assert property (p_tickOne) else $error("tick longer than a cycle");
  property p_evOne; eventMark |=> !eventMark; endproperty
  a_evOne: assert property (p_evOne) else $error("event mark longer than a cycle");
  property p_waitFirst; $rose(avsRead || avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest;
  endproperty
  a_waitFirst: assert property (p_waitFirst) else $error("wait state count wrong");
  property p_waitIdle; !(avsRead || avsWrite) |-> !avsWaitrequest; endproperty
  a_waitIdle: assert property (p_waitIdle) else $error("waitrequest without request");
  property p_preExcl; preTrigActive |-> !measuring; endproperty
  a_preExcl: assert property (p_preExcl) else $error("armed while measuring");
endmodule

bind eis_io_sync eis_io_sync_checker #(.SYNC_PHASE_CYC(SYNC_PHASE_CYC),
  .TRIG_PULSE_CYC(TRIG_PULSE_CYC)) uChk (.sysClk(sysClk), .arst_n(arst_n),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
  .syncOut(syncOut), .trigOut(trigOut), .trigOutOe(trigOutOe), .measuring(measuring),
  .sampleTick(sampleTick), .eventMark(eventMark), .preTrigActive(preTrigActive));

// *** eis_far_side.sv ***
// Upstream unit of the sync chain: a primary driving its CMOS sync output.
// Assumes the bench raises runSync to start the square wave.
`timescale 1ns/1ps
module eis_far_side
(
  // Control
  input wire logic runSync,
  // Sync line
  output logic syncLine
);
  // Period 160 ns, offset 3 ns off the system clock grid
  initial
  begin
    syncLine = 1'b0;
    forever
    begin
      @(posedge runSync);
      #3;
      // Always ends on a full low phase, so the line rests low
      while (runSync)
      begin
        #80 syncLine = 1'b1;
        #80 syncLine = 1'b0;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for eis_io_sync: registers, control pins, trigger, sync.
// Assumes eis_far_side as sync source and the checker bound to the top.
`timescale 1ns/1ps
module tb_top;
  localparam int PH = 8;
  logic sysClk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h00000000;
  logic [31:0] avsReaddata;
  logic avsWaitrequest, syncIn, syncOut, trigOut, trigOutOe;
  logic [2:0] ctrlIn = 3'h0;
  logic wirelessRegistered = 1'b0, timedStart = 1'b0, timedStop = 1'b0, runSync = 1'b0;
  logic measuring, sampleTick, eventMark, preTrigActive;
  int failures = 0, checks = 0, cycles = 0, evCnt = 0, tkCnt = 0;
  logic [31:0] d;
  always #5 sysClk = ~sysClk;
  eis_io_sync #(.SYNC_PHASE_CYC(PH), .SYNC_TIMEOUT_CYC(64), .TRIG_PULSE_CYC(50)) uut (
    .sysClk(sysClk), .arst_n(arst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .syncIn(syncIn), .syncOut(syncOut),
    .ctrlIn(ctrlIn), .trigOut(trigOut), .trigOutOe(trigOutOe),
    .wirelessRegistered(wirelessRegistered), .timedStart(timedStart),
    .timedStop(timedStop), .measuring(measuring), .sampleTick(sampleTick),
    .eventMark(eventMark), .preTrigActive(preTrigActive));
  eis_far_side uFar (.runSync(runSync), .syncLine(syncIn));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sysClk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waitrequest judged at the rising edge where the write lands and data is taken
  task automatic ack();
    do @(posedge sysClk); while (avsWaitrequest !== 1'b0);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge sysClk);
    avsAddress <= a;
    avsWritedata <= v;
    avsWrite <= 1'b1;
    ack();
    avsWrite <= 1'b0;
    repeat (4) @(posedge sysClk);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    @(posedge sysClk);
    avsAddress <= a;
    avsRead <= 1'b1;
    ack();
    d = avsReaddata;
    avsRead <= 1'b0;
    chk(nm, d & m, exp);
  endtask
  task automatic watch(input int n);
    repeat (n)
    begin
      @(negedge sysClk);
      evCnt += (eventMark === 1'b1);
      tkCnt += (sampleTick === 1'b1);
    end
  endtask
  // Each level held well past the synchroniser delay
  task automatic pin(input int i, input logic v);
    @(posedge sysClk);
    ctrlIn[i] <= v;
    watch(12);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tReset();
    rchk("ctrl", eis_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
    rchk("incfg", eis_pkg::OFS_INCFG, 32'hFFFFFFFF, 32'h00000000);
    wr(5'h10, 32'hFFFFFFFF);
    rchk("unmapped", 5'h10, 32'hFFFFFFFF, 32'h00000000);
    rchk("cmd", eis_pkg::OFS_CMD, 32'hFFFFFFFF, 32'h00000000);
    chk("syncOff", syncOut, 1'b0);
  endtask
  task automatic tInputs();
    wr(eis_pkg::OFS_INCFG, 32'h00000D29);
    pin(0, 1'b1);
    chk("startPin", measuring, 1'b1);
    pin(1, 1'b1);
    chk("stopWrongEdge", measuring, 1'b1);
    pin(1, 1'b0);
    chk("stopPin", measuring, 1'b0);
    pin(0, 1'b0);
    chk("startWrongEdge", measuring, 1'b0);
    evCnt = 0;
    pin(2, 1'b1);
    rchk("levels", eis_pkg::OFS_STATUS, 32'h00000700, 32'h00000400);
    pin(2, 1'b0);
    chk("events", evCnt, 1);
  endtask
  task automatic tToggle();
    wr(eis_pkg::OFS_INCFG, 32'h0000090B);
    pin(0, 1'b1);
    chk("toggleOn", measuring, 1'b1);
    pin(0, 1'b0);
    chk("toggleHold", measuring, 1'b1);
    pin(0, 1'b1);
    chk("toggleOff", measuring, 1'b0);
    pin(2, 1'b1);
    chk("in3NoStart", measuring, 1'b0);
    pin(0, 1'b0);
  endtask
  task automatic tTrigger();
    wr(eis_pkg::OFS_INCFG, 32'h00000400);
    wr(eis_pkg::OFS_CTRL, 32'h0000002C);
    wr(eis_pkg::OFS_CMD, 32'h00000001);
    rchk("armed", eis_pkg::OFS_STATUS, 32'h00000003, 32'h00000002);
    chk("preTrig", preTrigActive, 1'b1);
    pin(2, 1'b0);
    chk("trigRun", measuring, 1'b1);
    chk("trigOutOn", trigOutOe, 1'b1);
    wr(eis_pkg::OFS_CMD, 32'h00000002);
    chk("stopped", measuring, 1'b0);
    chk("pulseHeld", trigOutOe, 1'b1);
    watch(60);
    chk("pulseEnd", trigOutOe, 1'b0);
    wr(eis_pkg::OFS_CTRL, 32'h00000014);
    wr(eis_pkg::OFS_CMD, 32'h00000001);
    chk("runNoOut", trigOutOe, 1'b0);
    wr(eis_pkg::OFS_CMD, 32'h00000004);
    chk("stopTrig", measuring, 1'b0);
    chk("stopOut", trigOutOe, 1'b1);
    watch(60);
    chk("stopOutEnd", trigOutOe, 1'b0);
  endtask
  task automatic tPrimary();
    int n;
    n = 0;
    wr(eis_pkg::OFS_CTRL, 32'h00000001);
    do @(negedge sysClk); while (syncOut !== 1'b1);
    while (syncOut === 1'b1)
    begin
      @(negedge sysClk);
      n++;
    end
    chk("phase", n, PH);
    @(posedge sysClk);
    wirelessRegistered <= 1'b1;
    wr(eis_pkg::OFS_CMD, 32'h00000001);
    chk("wireless", measuring, 1'b0);
    rchk("refused", eis_pkg::OFS_STATUS, 32'h00000010, 32'h00000010);
    wr(eis_pkg::OFS_STATUS, 32'h00000010);
    rchk("refClr", eis_pkg::OFS_STATUS, 32'h00000010, 32'h00000000);
    wirelessRegistered <= 1'b0;
    wr(eis_pkg::OFS_CMD, 32'h00000001);
    chk("primStart", measuring, 1'b1);
    wr(eis_pkg::OFS_CMD, 32'h00000002);
    chk("primStop", measuring, 1'b0);
    // Leave early in a low phase so the output does not cut one short
    do @(negedge sysClk); while (syncOut !== 1'b1);
    do @(negedge sysClk); while (syncOut !== 1'b0);
    wr(eis_pkg::OFS_CTRL, 32'h00000000);
  endtask
  task automatic tSecondary();
    wr(eis_pkg::OFS_CTRL, 32'h00000042);
    wr(eis_pkg::OFS_CMD, 32'h00000001);
    chk("secKey", measuring, 1'b0);
    rchk("secRef", eis_pkg::OFS_STATUS, 32'h00000010, 32'h00000010);
    @(posedge sysClk);
    timedStart <= 1'b1;
    @(posedge sysClk);
    timedStart <= 1'b0;
    timedStop <= 1'b1;
    @(posedge sysClk);
    timedStop <= 1'b0;
    watch(4);
    chk("secTimed", measuring, 1'b0);
    wr(eis_pkg::OFS_INCFG, 32'h00000009);
    pin(0, 1'b1);
    chk("secPin", measuring, 1'b0);
    pin(0, 1'b0);
    tkCnt = 0;
    runSync <= 1'b1;
    watch(60);
    chk("secRun", measuring, 1'b1);
    chk("secTicks", tkCnt > 2, 1'b1);
    runSync <= 1'b0;
    watch(200);
    chk("errStop", measuring, 1'b0);
    rchk("errFlag", eis_pkg::OFS_STATUS, 32'h00000004, 32'h00000004);
    rchk("errMode", eis_pkg::OFS_CTRL, 32'h00000003, 32'h00000000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge sysClk);
    arst_n <= 1'b1;
    tReset();
    tInputs();
    tToggle();
    tTrigger();
    tPrimary();
    tSecondary();
    conclude();
  end
endmodule
